// ===== hw/tccu_device.sv
`timescale 1ns/1ps
`default_nettype none
module tccu_device #(
  parameter int NU = tccu_pkg::NUM_UNITS,
  parameter int TW = tccu_pkg::TMR_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Controller side
  tccu_if.dev                bus,
  // Pad levels of each unit pin, read even while driven
  input  wire logic [NU-1:0] remapped_pin_input,
  // Other capture sources
  input  wire logic          comparator_one_synced,
  input  wire logic          comparator_two_synced,
  input  wire logic          pin_change_event,
  input  wire logic          logic_cell_one_out,
  input  wire logic          logic_cell_two_out,
  input  wire logic          logic_cell_three_out,
  input  wire logic          logic_cell_four_out,
  // External timer clock pin
  input  wire logic          ext_timer_clock,
  // Compare results
  output logic      [NU-1:0] unit_pin,
  output logic      [NU-1:0] adc_trigger
);
  localparam int NRAW = NU + 8;

  logic [NRAW-1:0] raw_in;
  logic [NRAW-1:0] syn;
  logic            ext_prev_q;
  logic            ext_rise;
  logic            tick;
  logic [TW-1:0]   timer_q;
  logic [TW-1:0]   timer_d;

  // Every outside level is cleaned before edge detection
  assign raw_in = {ext_timer_clock, logic_cell_four_out, logic_cell_three_out,
                   logic_cell_two_out, logic_cell_one_out, pin_change_event,
                   comparator_two_synced, comparator_one_synced,
                   remapped_pin_input};

  tccu_sync #(
    .W (NRAW)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // Timer tick: synchronized external count or the instruction clock
  assign ext_rise = syn[NRAW-1] & ~ext_prev_q;
  assign tick = bus.tmr_ctrl[tccu_pkg::TMR_ON] &
                (bus.tmr_ctrl[tccu_pkg::TMR_EXT] ? ext_rise
                 : ~bus.tmr_ctrl[tccu_pkg::TMR_SLEEP]);
  assign timer_d = bus.tmr_wr ? bus.tmr_wdata
                 : tick       ? TW'(timer_q + 1'b1)
                 : timer_q;
  assign bus.timer_count = timer_q;

  // Shared timer; held count survives sleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_q    <= '0;
      ext_prev_q <= 1'b0;
    end else begin
      timer_q    <= timer_d;
      ext_prev_q <= syn[NRAW-1];
    end
  end

  // One identical slice per unit, each with its own control word
  for (genvar g = 0; g < NU; g++) begin : g_unit
    logic          en_q;
    logic [3:0]    mode_q;
    logic          src_prev_q;
    logic [3:0]    pre_q;
    logic [3:0]    pre_d;
    logic [TW-1:0] val_q;
    logic [TW-1:0] val_d;
    logic          flag_q;
    logic          out_q;
    logic          out_d;
    logic          trig_q;
    logic          match_q;
    logic [7:0]    srcs;
    logic [2:0]    sel;
    logic          src;
    logic          rise;
    logic          fall;
    logic          is_cap;
    logic          is_cmp;
    logic          cap_evt;
    logic          match;
    logic          hit;
    logic          zero_wr;

    // Source choice; pin source is this unit's own pad
    assign srcs = {syn[NU+6:NU], syn[g]};
    assign sel  = bus.cap_sel[g*3 +: 3];
    assign src  = srcs[sel];
    assign rise = src & ~src_prev_q;
    assign fall = ~src & src_prev_q;

    // Mode decode; capture codes share the 01xx pattern
    assign is_cap = en_q & (mode_q[3:2] == 2'b01);
    assign is_cmp = en_q & ((mode_q == tccu_pkg::MODE_CMP_TOGGLE) |
                    (mode_q >= tccu_pkg::MODE_CMP_SET &&
                     mode_q <= tccu_pkg::MODE_CMP_TRIG));

    // Capture event per edge mode and prescale position
    assign cap_evt = is_cap &
      ((mode_q == tccu_pkg::MODE_CAP_FALL)  ? fall
     : (mode_q == tccu_pkg::MODE_CAP_RISE)  ? rise
     : (mode_q == tccu_pkg::MODE_CAP_RISE4) ? rise & (pre_q[1:0] == tccu_pkg::PRE4_LAST)
     : rise & (pre_q == tccu_pkg::PRE16_LAST));

    // Counter runs on rises in every capture mode; a mode change
    // alone leaves it, so the next event may come early
    assign pre_d = !is_cap ? tccu_pkg::PRE_RST
                 : rise    ? 4'(pre_q + 1'b1)
                 : pre_q;

    // Capture beats a software load of the same cycle
    assign val_d = cap_evt        ? timer_q
                 : bus.val_wr[g]  ? bus.val_wdata
                 : val_q;

    // Match is edge-qualified so a paused timer acts only once
    assign match = is_cmp & (val_q == timer_q);
    assign hit   = match & ~match_q;

    // Pin action on a match; a zero control write wins
    assign zero_wr = bus.con_wr[g] & (bus.con_wdata == tccu_pkg::CON_RST);
    assign out_d = zero_wr ? 1'b0
                 : !hit    ? out_q
                 : (mode_q == tccu_pkg::MODE_CMP_TOGGLE) ? ~out_q
                 : (mode_q == tccu_pkg::MODE_CMP_SET)    ? 1'b1
                 : (mode_q == tccu_pkg::MODE_CMP_CLR)    ? 1'b0
                 : out_q;

    // Control word and edge history
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        en_q       <= 1'b0;
        mode_q     <= tccu_pkg::CON_RST[3:0];
        src_prev_q <= 1'b0;
        pre_q      <= tccu_pkg::PRE_RST;
      end else begin
        if (bus.con_wr[g]) begin
          en_q   <= bus.con_wdata[tccu_pkg::CON_EN_BIT];
          mode_q <= bus.con_wdata[3:0];
        end
        src_prev_q <= src;
        pre_q      <= pre_d;
      end
    end

    // Value, flag, pin latch and converter strobe
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        val_q   <= '0;
        flag_q  <= 1'b0;
        out_q   <= 1'b0;
        trig_q  <= 1'b0;
        match_q <= 1'b0;
      end else begin
        val_q   <= val_d;
        // Set beats clear; only flag_clr clears it, from software or the mode-change walk
        flag_q  <= (cap_evt | hit) | (flag_q & ~bus.flag_clr[g]);
        out_q   <= out_d;
        trig_q  <= hit & (mode_q == tccu_pkg::MODE_CMP_TRIG);
        match_q <= match;
      end
    end

    assign bus.val_rdata[g*TW +: TW] = val_q;
    assign bus.flag[g]   = flag_q;
    assign unit_pin[g]   = out_q;
    assign adc_trigger[g] = trig_q;
  end
endmodule
`default_nettype wire

// ===== hw/tccu_host.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Software-facing controller: Avalon-MM slave that drives the units
module tccu_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Combined unit interrupt
  output logic             irq,
  // Unit side
  tccu_if.host             bus
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ZERO = 3'b010,
    H_LOAD = 3'b100
  } tccu_hstate_t;

  tccu_hstate_t st_q;
  logic [7:0]  con_q [2];
  logic [7:0]  new_q;
  logic        unit_q;
  logic [5:0]  sel_q;
  logic [1:0]  ie_q;
  logic [2:0]  tctl_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        irq_q;
  logic [1:0]  con_wr_q;
  logic [7:0]  con_wdata_q;
  logic [1:0]  val_wr_q;
  logic [15:0] wdata16_q;
  logic [1:0]  flag_clr_q;
  logic        tmr_wr_q;

  logic        is_unit;
  logic        u;
  logic [1:0]  slot;
  logic        acc_w;
  logic        con_w;
  logic        mode_chg;
  logic        quiet;
  logic [31:0] rd_mux;

  // Decode of the byte address
  assign is_unit  = ~avs_address[5];
  assign u        = avs_address[4];
  assign slot     = avs_address[3:2];
  assign acc_w    = avs_write & ~wait_q;
  assign con_w    = acc_w & is_unit & (slot == tccu_pkg::SLOT_CON);
  // Any mode change on a running unit passes through an all-zero word
  assign mode_chg = con_q[u][tccu_pkg::CON_EN_BIT] &
                    (con_q[u] != avs_writedata[7:0]);
  // Busy until a pending flag clear has landed, so no stale flag leaks
  assign quiet    = (st_q == H_IDLE) & ~|flag_clr_q;
  assign rd_mux = !is_unit ?
      ((avs_address == tccu_pkg::REG_TMR_CTRL)  ? {29'h0, tctl_q}
     : (avs_address == tccu_pkg::REG_TMR_COUNT) ? {16'h0, bus.timer_count}
     : 32'h0)
    : (slot == tccu_pkg::SLOT_CON)    ? {24'h0, con_q[u]}
    : (slot == tccu_pkg::SLOT_CAPSEL) ? {29'h0, sel_q[u*3 +: 3]}
    : (slot == tccu_pkg::SLOT_VALUE)  ? {16'h0, bus.val_rdata[u*16 +: 16]}
    : {30'h0, ie_q[u], bus.flag[u]};

  // Answer one cycle after the request; held off during a mode change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(wait_q & (avs_read | avs_write) & quiet & ~con_w);
      if (avs_read & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Mode-change walk: zero word, new word, then flag clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= H_IDLE;
      con_q[0]    <= tccu_pkg::CON_RST;
      con_q[1]    <= tccu_pkg::CON_RST;
      new_q       <= tccu_pkg::CON_RST;
      unit_q      <= 1'b0;
      con_wr_q    <= 2'h0;
      con_wdata_q <= tccu_pkg::CON_RST;
      flag_clr_q  <= 2'h0;
    end else begin
      con_wr_q   <= 2'h0;
      flag_clr_q <= 2'h0;
      unique case (st_q)
        H_IDLE: begin
          if (con_w) begin
            con_q[u]    <= avs_writedata[7:0];
            new_q       <= avs_writedata[7:0];
            unit_q      <= u;
            con_wr_q[u] <= 1'b1;
            con_wdata_q <= mode_chg ? tccu_pkg::CON_RST : avs_writedata[7:0];
            st_q        <= mode_chg ? H_ZERO : H_IDLE;
          end else if (acc_w & is_unit & (slot == tccu_pkg::SLOT_FLAG)) begin
            flag_clr_q[u] <= avs_writedata[tccu_pkg::FLAG_BIT];
          end
        end
        H_ZERO: begin
          con_wr_q[unit_q] <= 1'b1;
          con_wdata_q      <= new_q;
          st_q             <= H_LOAD;
        end
        H_LOAD: begin
          flag_clr_q[unit_q] <= 1'b1;
          st_q               <= H_IDLE;
        end
      endcase
    end
  end

  // Plain settings and one-cycle load strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q     <= 6'h0;
      ie_q      <= 2'h0;
      tctl_q    <= 3'h0;
      val_wr_q  <= 2'h0;
      tmr_wr_q  <= 1'b0;
      wdata16_q <= 16'h0;
      irq_q     <= 1'b0;
    end else begin
      val_wr_q  <= 2'h0;
      tmr_wr_q  <= 1'b0;
      wdata16_q <= avs_writedata[15:0];
      if (acc_w & is_unit & (slot == tccu_pkg::SLOT_CAPSEL)) begin
        sel_q[u*3 +: 3] <= avs_writedata[2:0];
      end
      if (acc_w & is_unit & (slot == tccu_pkg::SLOT_VALUE)) begin
        val_wr_q[u] <= 1'b1;
      end
      if (acc_w & is_unit & (slot == tccu_pkg::SLOT_FLAG)) begin
        ie_q[u] <= avs_writedata[tccu_pkg::IE_BIT];
      end
      if (acc_w & (avs_address == tccu_pkg::REG_TMR_CTRL)) begin
        tctl_q <= avs_writedata[2:0];
      end
      tmr_wr_q <= acc_w & (avs_address == tccu_pkg::REG_TMR_COUNT);
      // Masked while a mode change is in flight
      irq_q <= |(bus.flag & ie_q) & quiet;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign bus.con_wr      = con_wr_q;
  assign bus.con_wdata   = con_wdata_q;
  assign bus.cap_sel     = sel_q;
  assign bus.val_wr      = val_wr_q;
  assign bus.val_wdata   = wdata16_q;
  assign bus.flag_clr    = flag_clr_q;
  assign bus.tmr_wr      = tmr_wr_q;
  assign bus.tmr_wdata   = wdata16_q;
  assign bus.tmr_ctrl    = tctl_q;
endmodule
`default_nettype wire

// ===== hw/tccu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tccu_if;
  // Orders from the controller
  logic [1:0]  con_wr;
  logic [7:0]  con_wdata;
  logic [5:0]  cap_sel;
  logic [1:0]  val_wr;
  logic [15:0] val_wdata;
  logic [1:0]  flag_clr;
  logic        tmr_wr;
  logic [15:0] tmr_wdata;
  logic [2:0]  tmr_ctrl;
  // State returned by the units
  logic [31:0] val_rdata;
  logic [1:0]  flag;
  logic [15:0] timer_count;

  modport dev (
    input  con_wr, con_wdata, cap_sel, val_wr, val_wdata, flag_clr,
    input  tmr_wr, tmr_wdata, tmr_ctrl,
    output val_rdata, flag, timer_count
  );
  modport host (
    output con_wr, con_wdata, cap_sel, val_wr, val_wdata, flag_clr,
    output tmr_wr, tmr_wdata, tmr_ctrl,
    input  val_rdata, flag, timer_count
  );
endinterface
`default_nettype wire

// ===== hw/tccu_pkg.sv
package tccu_pkg;
  // Shape of the block
  localparam int NUM_UNITS = 2;
  localparam int TMR_W     = 16;
  localparam int SRC_SEL_W = 3;
  // Control word layout and reset value
  localparam int         CON_EN_BIT = 7;
  localparam logic [7:0] CON_RST    = 8'h00;
  // Mode codes held in the low nibble of the control word
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR    = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI    = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG   = 4'hb;
  // Edge prescaler
  localparam logic [3:0] PRE_RST     = 4'h0;
  localparam logic [1:0] PRE4_LAST   = 2'h3;
  localparam logic [3:0] PRE16_LAST  = 4'hf;
  // Avalon byte addresses: unit block base and stride, word slots
  localparam logic [5:0] REG_UNIT0     = 6'h00;
  localparam logic [5:0] REG_UNIT1     = 6'h10;
  localparam logic [1:0] SLOT_CON      = 2'h0;
  localparam logic [1:0] SLOT_CAPSEL   = 2'h1;
  localparam logic [1:0] SLOT_VALUE    = 2'h2;
  localparam logic [1:0] SLOT_FLAG     = 2'h3;
  localparam logic [5:0] REG_TMR_CTRL  = 6'h20;
  localparam logic [5:0] REG_TMR_COUNT = 6'h24;
  // Bit positions in flag and timer control words
  localparam int FLAG_BIT  = 0;
  localparam int IE_BIT    = 1;
  localparam int TMR_ON    = 0;
  localparam int TMR_EXT   = 1;
  localparam int TMR_SLEEP = 2;
endpackage

// ===== hw/tccu_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a bit changes once stages two and three agree
module tccu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Asynchronous levels and their clean copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] agree;

  // Disagreement keeps the old value, filtering one-cycle glitches
  assign agree    = ~(s2_q ^ s3_q);
  assign sync_out = out_q;

  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (s3_q & agree) | (out_q & ~agree);
    end
  end
endmodule
`default_nettype wire

// ===== verification/tccu_props.sv
`timescale 1ns/1ps
`default_nettype none
// Link checks between controller and units; unit 0 is shadowed
module tccu_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Link signals
  input wire logic [1:0]  con_wr,
  input wire logic [7:0]  con_wdata,
  input wire logic [1:0]  val_wr,
  input wire logic [15:0] val_wdata,
  input wire logic [1:0]  flag_clr,
  input wire logic        tmr_wr,
  input wire logic [2:0]  tmr_ctrl,
  input wire logic [31:0] val_rdata,
  input wire logic [1:0]  flag,
  input wire logic [15:0] timer_count
);
  logic        en0_q;
  logic [3:0]  md0_q;
  logic [15:0] wd0_q;

  // Shadow of unit 0 control and last loaded value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en0_q <= 1'b0;
      md0_q <= 4'h0;
      wd0_q <= 16'h0;
    end else begin
      if (con_wr[0]) begin
        en0_q <= con_wdata[tccu_pkg::CON_EN_BIT];
        md0_q <= con_wdata[3:0];
      end
      if (val_wr[0]) begin
        wd0_q <= val_wdata;
      end
    end
  end

  // Mode classes; other codes leave the unit idle
  wire cap0 = en0_q && md0_q >= tccu_pkg::MODE_CAP_FALL
              && md0_q <= tccu_pkg::MODE_CAP_RISE16;
  wire cmp0 = en0_q && (md0_q == tccu_pkg::MODE_CMP_TOGGLE
              || (md0_q >= tccu_pkg::MODE_CMP_SET && md0_q <= tccu_pkg::MODE_CMP_TRIG));
  wire eq0  = timer_count == val_rdata[15:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_zero_new;
    con_wr[0] && con_wdata == 8'h00 ##1 con_wr[0] && con_wdata[7];
  endsequence
  sequence s_steady(logic [2:0] c);
    tmr_ctrl == c && !tmr_wr ##1 tmr_ctrl == c && !tmr_wr;
  endsequence

  property p_flag_hold;
    $fell(flag[0]) |-> $past(flag_clr[0]);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag fell unasked");
  property p_zero_first;
    con_wr[0] && con_wdata[tccu_pkg::CON_EN_BIT] && en0_q |-> con_wdata[3:0] == md0_q;
  endproperty
  a_zero_first: assert property (p_zero_first) else $error("mode changed live");
  property p_walk_clear;
    s_zero_new |=> flag_clr[0];
  endproperty
  a_walk_clear: assert property (p_walk_clear) else $error("no clear after walk");
  property p_val_load;
    val_wr[0] && !cap0 |=> ##[0:1] val_rdata[15:0] == wd0_q;
  endproperty
  a_val_load: assert property (p_val_load) else $error("value not loaded");
  property p_cmp_stable;
    cmp0 && !val_wr[0] && !$past(val_wr[0]) |=> $stable(val_rdata[15:0]);
  endproperty
  a_cmp_stable: assert property (p_cmp_stable) else $error("compare value moved");
  property p_cap_flag;
    cap0 && $past(cap0) && !$past(val_wr[0]) && $changed(val_rdata[15:0]) |-> flag[0];
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture without flag");
  property p_match_flag;
    $rose(eq0) && cmp0 && tmr_ctrl == 3'h1 |-> ##[0:2] flag[0];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match without flag");
  property p_tmr_run;
    s_steady(3'h1) |=> timer_count == $past(timer_count) + 16'h1;
  endproperty
  a_tmr_run: assert property (p_tmr_run) else $error("timer not counting");
  property p_tmr_sleep;
    s_steady(3'h5) |=> $stable(timer_count);
  endproperty
  a_tmr_sleep: assert property (p_tmr_sleep) else $error("timer ran in sleep");
  property p_unit_iso;
    val_wr[1] && !val_wr[0] && !cap0 |=> $stable(val_rdata[15:0]);
  endproperty
  a_unit_iso: assert property (p_unit_iso) else $error("unit 0 disturbed");
endmodule
`default_nettype wire

// ===== verification/timer_capture_compare_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Controller and units joined; software side driven over Avalon-MM
module timer_capture_compare_unit_tb_top;
  localparam logic [3:0] CM [5] = '{tccu_pkg::MODE_CMP_SET, tccu_pkg::MODE_CMP_CLR,
    tccu_pkg::MODE_CMP_TOGGLE, tccu_pkg::MODE_CMP_TRIG, tccu_pkg::MODE_CMP_SWI};
  logic        clk;
  logic        rstn;
  logic [5:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wreq;
  logic        irq;
  logic [1:0]  pin_in;
  logic [6:0]  src;
  logic        ext_clk;
  logic [1:0]  unit_pin;
  logic [1:0]  adc_trig;
  logic [31:0] rv;
  logic [15:0] t;
  int          fail_count;
  int          checked;
  int          adc_cnt = 0;
  integer      seed = 32'h58e3;

  tccu_if bif ();
  tccu_host i_tccu_host (.clk, .rstn, .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq), .irq, .bus(bif));
  tccu_device i_tccu_device (.clk, .rstn, .bus(bif), .remapped_pin_input(pin_in),
    .comparator_one_synced(src[0]), .comparator_two_synced(src[1]),
    .pin_change_event(src[2]), .logic_cell_one_out(src[3]), .logic_cell_two_out(src[4]),
    .logic_cell_three_out(src[5]), .logic_cell_four_out(src[6]),
    .ext_timer_clock(ext_clk), .unit_pin, .adc_trigger(adc_trig));
  tccu_props i_tccu_props (.clk, .rstn, .con_wr(bif.con_wr), .con_wdata(bif.con_wdata),
    .val_wr(bif.val_wr), .val_wdata(bif.val_wdata), .flag_clr(bif.flag_clr),
    .tmr_wr(bif.tmr_wr), .tmr_ctrl(bif.tmr_ctrl), .val_rdata(bif.val_rdata),
    .flag(bif.flag), .timer_count(bif.timer_count));

  // Free-running bench clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Converter trigger pulses of unit 0, counted as they stand
  always @(posedge clk) begin
    if (adc_trig[0] === 1'b1) adc_cnt <= adc_cnt + 1;
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; held until waitrequest is sampled low, then a gap
  // The watchdog alone bounds a wait that never ends
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv, e, "readdata");
  endtask

  function automatic logic [5:0] ra(input int g, input logic [1:0] sl);
    return (g == 0 ? tccu_pkg::REG_UNIT0 : tccu_pkg::REG_UNIT1) + {2'h0, sl, 2'h0};
  endfunction

  function automatic logic [31:0] con_on(input logic [3:0] m);
    return {24'h0, 4'h8, m};
  endfunction

  // Pin level after the k-th match of a compare mode
  function automatic logic exp_pin(input logic [3:0] m, input int k);
    if (m == tccu_pkg::MODE_CMP_SET) return 1'b1;
    if (m == tccu_pkg::MODE_CMP_TOGGLE) return k == 0;
    return 1'b0;
  endfunction

  // Source 0 is the unit's own pad; levels last past the synchroniser
  task automatic drive(input int g, input int s, input logic v);
    if (s == 0) pin_in[g] <= v;
    else src[s-1] <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic pulses(input int s, input int n);
    repeat (n) begin
      drive(0, s, 1'b1);
      drive(0, s, 1'b0);
    end
  endtask

  initial begin
    int g;
    int s;
    int i;
    int k;
    int base;
    logic [15:0] r1;
    rstn = 1'b0;
    addr = 6'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    pin_in = 2'h0;
    src = 7'h0;
    ext_clk = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(ra(0, tccu_pkg::SLOT_VALUE), 32'h0);
    xfer(1'b1, 6'h3c, 32'hffff_ffff);
    rdchk(6'h3c, 32'h0);
    // Every source on both units, timer stopped so the count is exact
    for (g = 0; g < 2; g++) begin
      for (s = 0; s < 8; s++) begin
        t = 16'($random(seed));
        xfer(1'b1, tccu_pkg::REG_TMR_COUNT, {16'h0, t});
        xfer(1'b1, ra(g, tccu_pkg::SLOT_CAPSEL), s);
        xfer(1'b1, ra(g, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_RISE));
        drive(g, s, 1'b1);
        rdchk(ra(g, tccu_pkg::SLOT_VALUE), {16'h0, t});
        rdchk(ra(g, tccu_pkg::SLOT_FLAG), 32'h1);
        rdchk(ra(1 - g, tccu_pkg::SLOT_FLAG), 32'h0);
        xfer(1'b1, ra(g, tccu_pkg::SLOT_FLAG), 32'h1);
        drive(g, s, 1'b0);
        rdchk(ra(g, tccu_pkg::SLOT_FLAG), 32'h0);
        xfer(1'b1, ra(g, tccu_pkg::SLOT_CON), 32'h0);
      end
    end
    // Falling edges, second capture overwrites the unread first
    drive(0, 1, 1'b1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CAPSEL), 32'h1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_FALL));
    for (k = 0; k < 2; k++) begin
      t = 16'($random(seed));
      xfer(1'b1, tccu_pkg::REG_TMR_COUNT, {16'h0, t});
      drive(0, 1, 1'b0);
      drive(0, 1, 1'b1);
    end
    rdchk(ra(0, tccu_pkg::SLOT_VALUE), {16'h0, t});
    // Prescalers; a live change must go through off and lose the count
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), 32'h0);
    drive(0, 1, 1'b0);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_FLAG), 32'h1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_RISE4));
    pulses(1, 3);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h0);
    pulses(1, 3);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_RISE16));
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h0);
    pulses(1, 15);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h0);
    pulses(1, 1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_FLAG), 32'h2);
    repeat (4) @(posedge clk);
    chk(irq, 1'b1, "irq");
    xfer(1'b1, ra(0, tccu_pkg::SLOT_FLAG), 32'h3);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0, "irq");
    // Every compare action, two matches each
    for (i = 0; i < 5; i++) begin
      xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h0);
      xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), 32'h0);
      repeat (2) @(posedge clk);
      chk(unit_pin[0], 1'b0, "pin");
      xfer(1'b1, ra(0, tccu_pkg::SLOT_FLAG), 32'h1);
      t = 16'($random(seed)) & 16'h7fff;
      xfer(1'b1, ra(0, tccu_pkg::SLOT_VALUE), {16'h0, t + 16'h8});
      xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(CM[i]));
      base = adc_cnt;
      for (k = 0; k < 2; k++) begin
        xfer(1'b1, tccu_pkg::REG_TMR_COUNT, {16'h0, t});
        xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h0);
        chk(unit_pin[0], exp_pin(CM[i], k), "pin");
      end
      rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h1);
      chk(adc_cnt - base, (CM[i] == tccu_pkg::MODE_CMP_TRIG) ? 2 : 0, "triggers");
    end
    xfer(1'b1, ra(1, tccu_pkg::SLOT_VALUE), {16'h0, t});
    rdchk(ra(1, tccu_pkg::SLOT_VALUE), {16'h0, t});
    // Unit 1 compare drives its own pin only
    xfer(1'b1, ra(1, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CMP_SET));
    xfer(1'b1, tccu_pkg::REG_TMR_COUNT, {16'h0, t - 16'h4});
    xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    chk(unit_pin, 2'h2, "pins");
    // Sleep: internal clock halts, external clock keeps counting
    xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h5);
    xfer(1'b0, tccu_pkg::REG_TMR_COUNT, 32'h0);
    r1 = rv[15:0];
    repeat (10) @(posedge clk);
    rdchk(tccu_pkg::REG_TMR_COUNT, {16'h0, r1});
    xfer(1'b1, tccu_pkg::REG_TMR_CTRL, 32'h7);
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    rdchk(tccu_pkg::REG_TMR_COUNT, {16'h0, r1 + 16'h5});
    // Reset in mid-count clears the prescaler and held state
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_RISE4));
    pulses(1, 2);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h0);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CAPSEL), 32'h1);
    xfer(1'b1, ra(0, tccu_pkg::SLOT_CON), con_on(tccu_pkg::MODE_CAP_RISE4));
    pulses(1, 3);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h0);
    pulses(1, 1);
    rdchk(ra(0, tccu_pkg::SLOT_FLAG), 32'h1);
    final_report;
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule
`default_nettype wire
